// >>> logic/supervisor_pkg.sv
// Constants shared by the supervisor and its pin filter.
// Assumes a single 200 MHz clock and a classic Wishbone register bus.
//
// What this block does
// - Watchdog periods 200ms, 600ms, 1.4s, or off.
// - Period setting survives power loss.
// - Reset pin open drain, either polarity.
// - Supply low asserts reset at any time.
// - Reset asserted from power up onward.
// - Release after supply good for delay.
// - Expired watchdog asserts reset when enabled.
// - Start, clock low, then stop pattern clears watchdog.
// - Restart patterns watched whether addressed or not.
// - Protect pin high refuses period changes.
// - Period code 00/01/10/11 decode, 11 default.
package supervisor_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned T_WD_LONG_MS = 1400;
	localparam int unsigned T_WD_MID_MS = 600;
	localparam int unsigned T_WD_SHORT_MS = 200;
	localparam int unsigned T_RELEASE_MS = 200;
	localparam int unsigned WD_LONG_CYC = T_WD_LONG_MS * CYC_PER_MS;
	localparam int unsigned WD_MID_CYC = T_WD_MID_MS * CYC_PER_MS;
	localparam int unsigned WD_SHORT_CYC = T_WD_SHORT_MS * CYC_PER_MS;
	localparam int unsigned RELEASE_CYC = T_RELEASE_MS * CYC_PER_MS;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] CTRL_ADR = 4'h0;
	localparam logic [3:0] STAT_ADR = 4'h4;
	localparam int PER_HI_BIT = 6;
	localparam int PER_LO_BIT = 5;
	localparam int RWL_BIT = 2;
	localparam int WL_BIT = 1;
	localparam int ST_RST_BIT = 0;
	localparam int ST_LOW_BIT = 1;
	localparam int ST_WP_BIT = 2;
	localparam int ST_WDF_BIT = 3;
	localparam logic [7:0] CTRL_SET_WL = 8'h02;
	localparam logic [7:0] CTRL_CLR_WL = 8'h00;
	localparam logic [7:0] CTRL_SET_RWL = 8'h06;
	localparam logic [7:0] CTRL_VAL_MASK = 8'h9F;
	localparam logic [7:0] CTRL_VAL_FORM = 8'h02;

	// ----------------------------------------
	// Period codes and pins
	// ----------------------------------------
	localparam logic [1:0] PER_LONG = 2'b00;
	localparam logic [1:0] PER_MID = 2'b01;
	localparam logic [1:0] PER_SHORT = 2'b10;
	localparam logic [1:0] PER_OFF = 2'b11;
	localparam int PIN_N = 4;
	localparam int PIN_SDA = 0;
	localparam int PIN_SCL = 1;
	localparam int PIN_WP = 2;
	localparam int PIN_LOW = 3;
	// Bus idle high, protect off, supply assumed low until seen good
	localparam logic [3:0] PIN_RST_VAL = 4'b1011;

	typedef enum logic [1:0] {
		KICK_IDLE,
		KICK_START,
		KICK_ARMED
	} kick_state_e;

endpackage : supervisor_pkg

// >>> logic/pin_if.sv
// Carrier between the supervisor and its pin filter.
// Assumes raw pins are asynchronous to the filter clock.
`timescale 1ns/1ps
interface pin_if #(
	parameter int N = 4
);
	logic [N-1:0] raw;
	logic [N-1:0] clean;

	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface : pin_if

// >>> logic/pin_filter.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the pins may change at any time relative to clk_i.
`timescale 1ns/1ps
module pin_filter #(
	parameter int N = 4,
	parameter logic [N-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	pin_if.filt pins
);

	logic [N-1:0] s1_q;
	logic [N-1:0] s2_q;
	logic [N-1:0] s3_q;
	logic [N-1:0] clean_q;

	// ----------------------------------------
	// Per-pin chain
	// ----------------------------------------
	// Stage one feeds stage two only; a change is taken once two and three agree
	for (genvar i = 0; i < N; i++) begin : g_pin
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				s1_q[i] <= RST_VAL[i];
				s2_q[i] <= RST_VAL[i];
				s3_q[i] <= RST_VAL[i];
				clean_q[i] <= RST_VAL[i];
			end else begin
				s1_q[i] <= pins.raw[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (s2_q[i] == s3_q[i]) begin
					clean_q[i] <= s3_q[i];
				end
			end
		end
	end

	assign pins.clean = clean_q;

endmodule : pin_filter

// >>> logic/supervisor_wdt.sv
// Supply supervisor with watchdog and Wishbone control registers.
// Assumes synchronous active-high reset models power-up of the part;
// factory_init_i alone restores the retained period setting.
`timescale 1ns/1ps
module supervisor_wdt
	import supervisor_pkg::*;
#(
	parameter logic ACTIVE_HIGH = 1'b0,
	parameter logic [31:0] REL_CYC = RELEASE_CYC,
	parameter logic [31:0] WD_L_CYC = WD_LONG_CYC,
	parameter logic [31:0] WD_M_CYC = WD_MID_CYC,
	parameter logic [31:0] WD_S_CYC = WD_SHORT_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic factory_init_i,
	input wire logic [3:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire logic sda_i,
	input wire logic scl_i,
	input wire logic wp_i,
	input wire logic supply_low_i,
	output logic reset_pin_o,
	output logic reset_pin_oe_o
);

	// ----------------------------------------
	// Pin conditioning
	// ----------------------------------------
	pin_if #(.N(PIN_N)) pins ();

	assign pins.raw = {supply_low_i, wp_i, scl_i, sda_i};

	pin_filter #(
		.N(PIN_N),
		.RST_VAL(PIN_RST_VAL)
	) u_filter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pins(pins)
	);

	wire sda = pins.clean[PIN_SDA];
	wire scl = pins.clean[PIN_SCL];
	wire wp = pins.clean[PIN_WP];
	wire supply_low = pins.clean[PIN_LOW];

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [1:0] period_q;
	logic write_latch_q;
	logic register_write_latch_q;
	logic rst_active_q;
	logic [31:0] rel_cnt_q;
	logic [31:0] wd_cnt_q;
	logic wd_fired_q;
	logic sda_prev_q;
	logic scl_prev_q;
	kick_state_e kick_q;
	kick_state_e kick_d;
	logic ack_q;
	logic [31:0] dat_q;
	logic oe_q;
	logic pin_q;

	// ----------------------------------------
	// Period decode
	// ----------------------------------------
	// Off code gives zero; callers must test enable separately
	function automatic logic [31:0] wd_limit_f(input logic [1:0] p);
		case (p)
			PER_LONG: wd_limit_f = WD_L_CYC;
			PER_MID: wd_limit_f = WD_M_CYC;
			PER_SHORT: wd_limit_f = WD_S_CYC;
			default: wd_limit_f = 32'h0000_0000;
		endcase
	endfunction : wd_limit_f

	wire [31:0] wd_limit = wd_limit_f(period_q);
	wire wd_en = (period_q != PER_OFF);
	wire wd_fire = wd_en && !rst_active_q && (wd_cnt_q == wd_limit - 32'h0000_0001);
	wire hold = supply_low || wd_fire;
	wire rel_done = (rel_cnt_q == REL_CYC - 32'h0000_0001);

	// ----------------------------------------
	// Restart pattern detection
	// ----------------------------------------
	// Watches the bus lines always, independent of any addressing
	wire sda_fall = sda_prev_q && !sda;
	wire sda_rise = !sda_prev_q && sda;
	wire scl_fall = scl_prev_q && !scl;
	wire bus_start = sda_fall && scl;
	wire bus_stop = sda_rise && scl;
	wire kick = (kick_q == KICK_ARMED) && bus_stop;

	// Start, then clock low, then stop restarts the watchdog
	always_comb begin
		kick_d = kick_q;
		case (kick_q)
			KICK_IDLE: begin
				if (bus_start) begin
					kick_d = KICK_START;
				end
			end
			KICK_START: begin
				if (bus_stop) begin
					kick_d = KICK_IDLE;
				end else if (scl_fall) begin
					kick_d = KICK_ARMED;
				end
			end
			KICK_ARMED: begin
				if (bus_start) begin
					kick_d = KICK_START;
				end else if (bus_stop) begin
					kick_d = KICK_IDLE;
				end
			end
			default: kick_d = KICK_IDLE;
		endcase
	end

	// Edge history and pattern state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sda_prev_q <= 1'b1;
			scl_prev_q <= 1'b1;
			kick_q <= KICK_IDLE;
		end else begin
			sda_prev_q <= sda;
			scl_prev_q <= scl;
			kick_q <= kick_d;
		end
	end

	// ----------------------------------------
	// Reset generation
	// ----------------------------------------
	// Any hold restarts the release delay, so good supply must be continuous
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rst_active_q <= 1'b1;
			rel_cnt_q <= 32'h0000_0000;
		end else if (hold) begin
			rst_active_q <= 1'b1;
			rel_cnt_q <= 32'h0000_0000;
		end else if (rst_active_q) begin
			if (rel_done) begin
				rst_active_q <= 1'b0;
			end else begin
				rel_cnt_q <= rel_cnt_q + 32'h0000_0001;
			end
		end
	end

	// Watchdog counter; cleared throughout reset so the host gets a full period
	always_ff @(posedge clk_i) begin
		if (rst_i || rst_active_q || kick || !wd_en) begin
			wd_cnt_q <= 32'h0000_0000;
		end else begin
			wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
		end
	end

	// Open-drain pin: low level only, enable carries the polarity
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oe_q <= !ACTIVE_HIGH;
			pin_q <= 1'b0;
		end else begin
			oe_q <= rst_active_q ^ ACTIVE_HIGH;
			pin_q <= 1'b0;
		end
	end

	assign reset_pin_o = pin_q;
	assign reset_pin_oe_o = oe_q;

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	wire req = cyc_i && stb_i;
	wire take = req && ack_q;
	wire hit_ctrl = (adr_i == CTRL_ADR);
	wire hit_stat = (adr_i == STAT_ADR);
	wire wr_ctrl = take && we_i && sel_i[0] && hit_ctrl;
	wire wr_stat = take && we_i && sel_i[0] && hit_stat;
	wire [7:0] wbyte = dat_i[7:0];
	wire is_value = ((wbyte & CTRL_VAL_MASK) == CTRL_VAL_FORM);
	wire [7:0] ctrl_rd = {1'b0, period_q, 2'b00, register_write_latch_q, write_latch_q, 1'b0};
	wire [7:0] stat_rd = {4'h0, wd_fired_q, wp, supply_low, rst_active_q};
	wire [31:0] rd_mux = hit_ctrl ? {24'h00_0000, ctrl_rd} :
		hit_stat ? {24'h00_0000, stat_rd} : 32'h0000_0000;
	wire nv_write = wr_ctrl && register_write_latch_q && is_value && !wbyte[RWL_BIT];

	// Ack one cycle after the request; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req && !ack_q;
			dat_q <= (req && !ack_q) ? rd_mux : 32'h0000_0000;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// Volatile latches: power up clear, three-step unlock sequence
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			write_latch_q <= 1'b0;
			register_write_latch_q <= 1'b0;
		end else if (wr_ctrl) begin
			if (register_write_latch_q) begin
				if (nv_write) begin
					register_write_latch_q <= 1'b0;
				end
			end else if (wbyte == CTRL_SET_WL) begin
				write_latch_q <= 1'b1;
			end else if (wbyte == CTRL_CLR_WL) begin
				write_latch_q <= 1'b0;
			end else if (wbyte == CTRL_SET_RWL && write_latch_q) begin
				register_write_latch_q <= 1'b1;
			end
		end
	end

	// Retained period; only factory init and register stores touch it, never power-up reset
	always_ff @(posedge clk_i) begin
		if (factory_init_i) begin
			period_q <= PER_OFF;
		end else if (nv_write && !wp && !rst_i) begin
			period_q <= {wbyte[PER_HI_BIT], wbyte[PER_LO_BIT]};
		end
	end

	// Sticky watchdog cause; a new expiry wins over a clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wd_fired_q <= 1'b0;
		end else if (wd_fire) begin
			wd_fired_q <= 1'b1;
		end else if (wr_stat && wbyte[ST_WDF_BIT]) begin
			wd_fired_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_fire;
		wd_fire;
	endsequence

	sequence s_released;
		$fell(rst_active_q);
	endsequence

	a_low_holds: assert property (supply_low |=> rst_active_q && rel_cnt_q == 32'h0)
		else $error("Supply low did not hold reset");

	a_por_holds: assert property ($fell(rst_i) |-> rst_active_q ##1 rst_active_q)
		else $error("Reset not held after power up");

	a_release_delay: assert property (s_released |-> $past(rel_done) && !$past(hold))
		else $error("Reset released before delay");

	a_wd_expiry: assert property (s_fire |=> rst_active_q ##1 wd_cnt_q == 32'h0)
		else $error("Watchdog expiry missed");

	a_kick_clears: assert property (kick && !rst_active_q |=> wd_cnt_q == 32'h0)
		else $error("Restart pattern did not clear count");

	a_wp_locks: assert property (wr_ctrl && wp |=> $stable(period_q))
		else $error("Period changed while protected");

	a_off_idle: assert property (period_q == PER_OFF |=> wd_cnt_q == 32'h0)
		else $error("Disabled watchdog counting");

	a_release_fresh: assert property (s_released |-> wd_cnt_q == 32'h0)
		else $error("Watchdog not restarted on release");

	a_pin_polarity: assert property (rst_active_q [*2] |=> reset_pin_oe_o == !ACTIVE_HIGH)
		else $error("Reset pin wrong level");

	a_short_decode: assert property (period_q == PER_SHORT |-> wd_limit == WD_S_CYC)
		else $error("Short period decode wrong");

	a_nv_keep: assert property (@(posedge clk_i) disable iff (factory_init_i)
		rst_i |=> $stable(period_q))
		else $error("Period lost across reset");

	a_unlock_order: assert property (nv_write && !wp |=> !register_write_latch_q)
		else $error("Register latch not cleared after store");

endmodule : supervisor_wdt

// >>> verif/host_kick_model.sv
// Host side of the watchdog link: one restart pattern per request.
// Assumes pull-ups hold both lines high between patterns.
`timescale 1ns/1ps
module host_kick_model (
	input wire logic kick_i,
	output logic sda_o,
	output logic scl_o
);
	// ----------------------------------------
	// Restart pattern on a 125 ns link clock
	// ----------------------------------------
	// Idle at pull-up level; the clock stands still outside a pattern
	initial begin
		sda_o = 1'b1;
		scl_o = 1'b1;
	end
	// Start, clock fall, clock rise, then stop
	always @(posedge kick_i) begin
		sda_o = 1'b0;
		#62.5 scl_o = 1'b0;
		#62.5 scl_o = 1'b1;
		#62.5 sda_o = 1'b1;
	end
endmodule : host_kick_model

// >>> verif/supervisor_wdt_test.sv
// Self-checking bench for the supply supervisor and its watchdog.
// Assumes shortened counts and a host model on the link lines.
`timescale 1ns/1ps
module supervisor_wdt_test;
	import supervisor_pkg::*;
	localparam int REL = 50;
	localparam int WD_TAB [3] = '{300, 200, 100};
	logic clk_i, rst_i, finit, we, cyc, stb, ack, sda, scl, wp, low, rpin, roe, kick;
	logic [3:0] adr, sel;
	logic [31:0] dat_w, dat_r;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	int n;

	supervisor_wdt #(.ACTIVE_HIGH(1'b0), .REL_CYC(32'(REL)), .WD_L_CYC(32'h0000_012C),
		.WD_M_CYC(32'h0000_00C8), .WD_S_CYC(32'h0000_0064)) DUT (.clk_i(clk_i),
		.rst_i(rst_i), .factory_init_i(finit), .adr_i(adr), .dat_i(dat_w), .dat_o(dat_r),
		.we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .sda_i(sda),
		.scl_i(scl), .wp_i(wp), .supply_low_i(low), .reset_pin_o(rpin),
		.reset_pin_oe_o(roe));
	host_kick_model host (.kick_i(kick), .sda_o(sda), .scl_o(scl));

	// ----------------------------------------
	// Clock, timeout and reporting
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// Whole run needs about 2200 cycles; a hang is cut off well above that
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 10000) begin
			mismatches++;
			summarize();
		end
	end
	task summarize;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// ----------------------------------------
	// Wishbone classic and link tasks
	// ----------------------------------------
	// Request held until ack is sampled high, then released for a cycle
	task wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= {24'h00_0000, d};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		check(32'(ack), 32'h0000_0001);
	endtask : wb
	task wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task rd_chk(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 8'h00, q);
		check(q, exp);
	endtask : rd_chk
	// Latch, both latches, then the value
	task store_period(input logic [7:0] v);
		wr(CTRL_ADR, CTRL_SET_WL);
		wr(CTRL_ADR, CTRL_SET_RWL);
		wr(CTRL_ADR, v);
	endtask : store_period
	// Pattern lasts about 38 cycles; the clear lands a few cycles later
	task do_kick;
		kick <= 1'b1;
		@(posedge clk_i);
		kick <= 1'b0;
		repeat (50) @(posedge clk_i);
	endtask : do_kick
	task wait_oe(input logic lvl, output int k);
		k = 0;
		while (roe !== lvl && k < 2000) begin
			@(posedge clk_i);
			k++;
		end
	endtask : wait_oe

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_i, finit, low, sel} = {3'b111, 4'hF};
		{we, cyc, stb, wp, kick, adr, dat_w} = '0;
		repeat (10) @(posedge clk_i);
		check(32'(roe), 32'h0000_0001);
		rst_i <= 1'b0;
		finit <= 1'b0;
		repeat (100) @(posedge clk_i);
		rd_chk(STAT_ADR, 32'h0000_0003);
		low <= 1'b0;
		wait_oe(1'b0, n);
		check(32'(n >= REL && n <= REL + 12), 32'h0000_0001);
		check(32'(rpin), 32'h0000_0000);
		rd_chk(CTRL_ADR, 32'h0000_0060);
		rd_chk(4'h8, 32'h0000_0000);
		repeat (400) @(posedge clk_i);
		check(32'(roe), 32'h0000_0000);
		// Each enabled period: kick, then time the expiry
		for (int i = 0; i < 3; i++) begin
			store_period({1'b0, 2'(i), 5'b00010});
			rd_chk(CTRL_ADR, {25'h000_0000, 2'(i), 5'b00010});
			do_kick();
			wait_oe(1'b1, n);
			check(32'(n > WD_TAB[i] - 20 && n <= WD_TAB[i]), 32'h0000_0001);
			rd_chk(STAT_ADR, 32'h0000_0009);
			wait_oe(1'b0, n);
			check(32'(n >= REL - 10 && n <= REL + 12), 32'h0000_0001);
			wr(STAT_ADR, 8'h08);
		end
		// Full period again after the release
		wait_oe(1'b1, n);
		check(32'(n >= 80 && n <= 100), 32'h0000_0001);
		wait_oe(1'b0, n);
		wr(STAT_ADR, 8'h08);
		repeat (8) do_kick();
		rd_chk(STAT_ADR, 32'h0000_0000);
		wp <= 1'b1;
		repeat (10) @(posedge clk_i);
		store_period(8'h02);
		rd_chk(CTRL_ADR, 32'h0000_0042);
		low <= 1'b1;
		wait_oe(1'b1, n);
		check(32'(n <= 8), 32'h0000_0001);
		// Power cycle keeps the period, drops the latches
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		check(32'(roe), 32'h0000_0001);
		rst_i <= 1'b0;
		low <= 1'b0;
		wait_oe(1'b0, n);
		check(32'(n >= REL && n <= REL + 12), 32'h0000_0001);
		rd_chk(CTRL_ADR, 32'h0000_0040);
		summarize();
	end
endmodule : supervisor_wdt_test
